// [hw/queue_echo_flags.sv]
// Purpose: Read-side qualification, flags and power-down for one queue
// Assumes: Reader, writer and register master run on core_clk
// Notes: power_down_n is a pin and passes a three-stage synchroniser
// How it works
// - Echo low when selected enabled read
// - Empty queue holds echo high
// - Echo is a registered output
// - Fall-through load: ready low, echo pulse
// - Bus driven only with select and enable
// - Read past last word: ready, echo high
// - Sync almost-full updates on clock only
// - Sync almost-full releases one cycle later
// - Sync almost-empty releases one cycle later
// - Flag mode latched during reset
// - Async almost-full follows transfers directly
// - Async almost-empty follows transfers directly
// - One microsecond wait after power-down
// - Control and offset registers frozen during power-down; interrupt enable and clear stay writable
// - Flags hold, outputs off in power-down
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module queue_echo_flags (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Write port
    input wire logic write_select_n,
    input wire logic write_enable_n,
    input wire logic [queue_pkg::DATA_W-1:0] write_data,
    // Read port
    input wire logic read_select_n,
    input wire logic read_enable_n,
    input wire logic output_enable_n,
    output logic [queue_pkg::DATA_W-1:0] data_out_bus,
    output logic data_out_oe,
    output logic echo_read_enable_n,
    // Flags
    output logic queue_empty_n,
    output logic output_ready_n,
    output logic almost_full_n,
    output logic almost_empty_n,
    // Static pins
    input wire logic flag_timing_select,
    input wire logic power_down_n,
    // Register port
    input wire logic [queue_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Interrupt
    output logic irq
);
    import queue_pkg::*;

    // ========================================================
    // State
    logic [DATA_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic [DATA_W-1:0] out_word;
    logic out_valid;
    logic flag_sync;
    logic fall_through_mode;
    logic [CNT_W-1:0] full_off;
    logic [CNT_W-1:0] empty_off;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic pd_s1;
    logic pd_s2;
    logic pd_s3;
    logic pd_n_q;
    logic [3:0] wake_cnt;

    // ========================================================
    // Power-down and wake
    wire live = pd_n_q && (wake_cnt == 4'h0);

    always_ff @(posedge core_clk) begin
        pd_s1 <= power_down_n;
        pd_s2 <= pd_s1;
        pd_s3 <= pd_s2;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pd_n_q <= 1'b1;
            wake_cnt <= 4'h0;
        end else begin
            if (pd_s2 == pd_s3) begin
                pd_n_q <= pd_s3;
            end
            if (!pd_n_q) begin
                wake_cnt <= WAKE_CYCLES;
            end else if (wake_cnt != 4'h0) begin
                wake_cnt <= wake_cnt - 4'h1;
            end
        end
    end

    // ========================================================
    // Transfer qualification
    wire wr_req = live && !write_select_n && !write_enable_n;
    wire wr_take = wr_req && (count != DEPTH_CNT);
    wire overflow = wr_req && (count == DEPTH_CNT);
    wire rd_req = live && !read_select_n && !read_enable_n;
    wire mem_has = count != {CNT_W{1'b0}};
    wire std_read = !fall_through_mode && rd_req && mem_has;
    wire ft_load = fall_through_mode && live && mem_has
        && (!out_valid || rd_req);
    wire ft_drain = fall_through_mode && live && out_valid && rd_req
        && !mem_has;
    wire rd_take = std_read || ft_load;
    wire next_echo = !rd_take;
    wire next_out_valid = ft_load ? 1'b1 : (ft_drain ? 1'b0 : out_valid);
    wire [CNT_W-1:0] next_count = count + CNT_W'(wr_take)
        - CNT_W'(rd_take);
    wire [CNT_W-1:0] level = count + CNT_W'(out_valid);
    wire [CNT_W-1:0] next_level = next_count + CNT_W'(next_out_valid);
    wire [CNT_W-1:0] free_now = DEPTH_CNT - count;
    wire [CNT_W-1:0] free_next = DEPTH_CNT - next_count;

    // ========================================================
    // Almost-full and almost-empty
    wire af_sync = !(free_now <= full_off);
    wire af_async = !(free_next <= full_off);
    wire ae_sync = !(level <= empty_off);
    wire ae_async = !(next_level <= empty_off);
    wire next_af = flag_sync ? af_sync : af_async;
    wire next_ae = flag_sync ? ae_sync : ae_async;

    // ========================================================
    // Queue storage and output register
    always_ff @(posedge core_clk) begin
        if (wr_take) begin
            mem[wr_ptr] <= write_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wr_ptr <= {PTR_W{1'b0}};
            rd_ptr <= {PTR_W{1'b0}};
            count <= {CNT_W{1'b0}};
            out_word <= {DATA_W{1'b0}};
            out_valid <= 1'b0;
        end else begin
            wr_ptr <= wr_take ? wr_ptr + PTR_W'(1) : wr_ptr;
            rd_ptr <= rd_take ? rd_ptr + PTR_W'(1) : rd_ptr;
            count <= next_count;
            out_word <= rd_take ? mem[rd_ptr] : out_word;
            out_valid <= next_out_valid;
        end
    end

    // ========================================================
    // Registered flags and echo
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            flag_sync <= flag_timing_select;
            echo_read_enable_n <= 1'b1;
            queue_empty_n <= 1'b0;
            output_ready_n <= 1'b1;
            almost_full_n <= 1'b1;
            almost_empty_n <= 1'b0;
        end else begin
            echo_read_enable_n <= next_echo;
            queue_empty_n <= fall_through_mode ? next_out_valid
                : (next_count != {CNT_W{1'b0}});
            output_ready_n <= !(fall_through_mode && next_out_valid);
            almost_full_n <= next_af;
            almost_empty_n <= next_ae;
        end
    end

    assign data_out_bus = out_word;
    assign data_out_oe = live && !read_select_n && !output_enable_n;

    // ========================================================
    // Register port
    wire cfg_we = reg_write && pd_n_q;
    wire ctrl_we = cfg_we && (reg_addr == CTRL_OFS);
    wire full_we = cfg_we && (reg_addr == FULL_OFS);
    wire empty_we = cfg_we && (reg_addr == EMPTY_OFS);
    wire irq_en_we = reg_write && (reg_addr == IRQ_EN_OFS);
    wire irq_clr_we = reg_write && (reg_addr == IRQ_CLR_OFS);
    wire [IRQ_W-1:0] irq_clear = irq_clr_we ? reg_wdata[IRQ_W-1:0]
        : {IRQ_W{1'b0}};
    wire [31:0] status_word = {21'h0, pd_n_q, live, flag_sync,
        out_valid, count};
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0;
        if (!reg_read) begin
            next_rdata = 32'h0;
        end else if (reg_addr == CTRL_OFS) begin
            next_rdata = {31'h0, fall_through_mode};
        end else if (reg_addr == FULL_OFS) begin
            next_rdata = {25'h0, full_off};
        end else if (reg_addr == EMPTY_OFS) begin
            next_rdata = {25'h0, empty_off};
        end else if (reg_addr == STATUS_OFS) begin
            next_rdata = status_word;
        end else if (reg_addr == IRQ_STAT_OFS) begin
            next_rdata = {28'h0, irq_status};
        end else if (reg_addr == IRQ_EN_OFS) begin
            next_rdata = {28'h0, irq_enable};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            fall_through_mode <= CTRL_RST;
            full_off <= FULL_OFS_RST;
            empty_off <= EMPTY_OFS_RST;
            irq_enable <= IRQ_EN_RST;
            reg_rdata <= 32'h0;
        end else begin
            if (ctrl_we) begin
                fall_through_mode <= reg_wdata[CTRL_FALL_THROUGH_MODE_BIT];
            end
            if (full_we) begin
                full_off <= reg_wdata[CNT_W-1:0];
            end
            if (empty_we) begin
                empty_off <= reg_wdata[CNT_W-1:0];
            end
            if (irq_en_we) begin
                irq_enable <= reg_wdata[IRQ_W-1:0];
            end
            reg_rdata <= next_rdata;
        end
    end

    // ========================================================
    // Interrupt status, set wins over clear
    wire [IRQ_W-1:0] irq_event;
    assign irq_event[IRQ_OVERFLOW_BIT] = overflow;
    assign irq_event[IRQ_AF_BIT] = almost_full_n && !next_af;
    assign irq_event[IRQ_AE_BIT] = almost_empty_n && !next_ae;
    assign irq_event[IRQ_WAKE_BIT] = pd_n_q && (wake_cnt == 4'h1);

    genvar gi;
    generate
        for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    irq_status[gi] <= 1'b0;
                end else begin
                    irq_status[gi] <= irq_event[gi]
                        || (irq_status[gi] && !irq_clear[gi]);
                end
            end
        end
    endgenerate

    assign irq = |(irq_status & irq_enable);

    // ========================================================
    // Assertions
    property p_echo_read;
        @(posedge core_clk) disable iff (!rstn)
        (!fall_through_mode && rd_req && mem_has) |=> !echo_read_enable_n;
    endproperty
    a_echo_read: assert property (p_echo_read)
        else $error("echo not low on selected read");

    property p_echo_empty;
        @(posedge core_clk) disable iff (!rstn)
        (!mem_has && !out_valid) |=> echo_read_enable_n;
    endproperty
    a_echo_empty: assert property (p_echo_empty)
        else $error("echo low while queue empty");

    property p_echo_cause;
        @(posedge core_clk) disable iff (!rstn)
        $fell(echo_read_enable_n) |-> $past(mem_has) && $past(live);
    endproperty
    a_echo_cause: assert property (p_echo_cause)
        else $error("echo fell without a stored word");

    property p_fall_in;
        @(posedge core_clk) disable iff (!rstn)
        (fall_through_mode && live && !out_valid && mem_has)
        |=> !output_ready_n && !echo_read_enable_n;
    endproperty
    a_fall_in: assert property (p_fall_in)
        else $error("fall-through load not flagged");

    property p_bus_drive;
        @(posedge core_clk) disable iff (!rstn)
        data_out_oe |-> !read_select_n && !output_enable_n && pd_n_q;
    endproperty
    a_bus_drive: assert property (p_bus_drive)
        else $error("bus driven without select and enable");

    property p_last_read;
        @(posedge core_clk) disable iff (!rstn)
        (fall_through_mode && live && out_valid && rd_req && !mem_has)
        |=> output_ready_n && echo_read_enable_n;
    endproperty
    a_last_read: assert property (p_last_read)
        else $error("read past last word not flagged");

    property p_af_sync;
        @(posedge core_clk) disable iff (!rstn)
        (flag_sync && $stable(full_off))
        |=> almost_full_n == !($past(free_now) <= $past(full_off));
    endproperty
    a_af_sync: assert property (p_af_sync)
        else $error("sync almost-full wrong");

    property p_ae_sync;
        @(posedge core_clk) disable iff (!rstn)
        (flag_sync && $stable(empty_off))
        |=> almost_empty_n == !($past(level) <= $past(empty_off));
    endproperty
    a_ae_sync: assert property (p_ae_sync)
        else $error("sync almost-empty wrong");

    property p_af_async;
        @(posedge core_clk) disable iff (!rstn)
        (!flag_sync && $stable(full_off) && $past(rstn))
        |-> almost_full_n == !(free_now <= full_off);
    endproperty
    a_af_async: assert property (p_af_async)
        else $error("async almost-full wrong");

    property p_ae_async;
        @(posedge core_clk) disable iff (!rstn)
        (!flag_sync && $stable(empty_off) && $past(rstn))
        |-> almost_empty_n == !(level <= empty_off);
    endproperty
    a_ae_async: assert property (p_ae_async)
        else $error("async almost-empty wrong");

    property p_mode_latch;
        @(posedge core_clk)
        $rose(rstn) |-> flag_sync == $past(flag_timing_select);
    endproperty
    a_mode_latch: assert property (p_mode_latch)
        else $error("flag mode not latched in reset");

    property p_wake;
        @(posedge core_clk) disable iff (!rstn)
        $rose(pd_n_q) |-> !live [*8] ##1 !live [*2] ##1 live;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake wait wrong length");

    property p_pd_static;
        @(posedge core_clk) disable iff (!rstn)
        !pd_n_q |=> $stable(fall_through_mode) && $stable(full_off)
            && $stable(empty_off);
    endproperty
    a_pd_static: assert property (p_pd_static)
        else $error("configuration changed in power-down");

    property p_pd_flags;
        @(posedge core_clk) disable iff (!rstn)
        (!pd_n_q && $past(!pd_n_q) && $past(rstn))
        |-> !data_out_oe ##1 ($stable(almost_full_n)
            && $stable(almost_empty_n));
    endproperty
    a_pd_flags: assert property (p_pd_flags)
        else $error("flags moved or bus on in power-down");

    c_fall_in: cover property (@(posedge core_clk) disable iff (!rstn)
        fall_through_mode && $fell(output_ready_n));
    c_drain: cover property (@(posedge core_clk) disable iff (!rstn)
        fall_through_mode && $rose(output_ready_n));
    c_af: cover property (@(posedge core_clk) disable iff (!rstn)
        $fell(almost_full_n));
    c_wake: cover property (@(posedge core_clk) disable iff (!rstn)
        $rose(live) && $past(pd_n_q));
endmodule : queue_echo_flags
`default_nettype wire

// [shared/queue_pkg.sv]
// Purpose: Constants shared by the queue read-side qualification block
// Assumes: One core clock at 10 MHz; byte-addressed register port
// Notes: Offsets are byte addresses of 32-bit words
package queue_pkg;
    // ========================================================
    // Geometry
    localparam int DATA_W = 10;
    localparam int DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] DEPTH_CNT = 7'h40;
    localparam int IRQ_W = 4;
    localparam int ADDR_W = 8;

    // ========================================================
    // Timing
    localparam int CLK_MHZ = 10;
    localparam int WAKE_NS = 1000;
    localparam int WAKE_CYCLES_INT = (WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] WAKE_CYCLES = 4'(WAKE_CYCLES_INT);
    localparam int QUIET_CYCLES = 4;

    // ========================================================
    // Register map
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] FULL_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] EMPTY_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] IRQ_EN_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] IRQ_CLR_OFS = 8'h18;

    // ========================================================
    // Field positions
    localparam int CTRL_FALL_THROUGH_MODE_BIT = 0;
    localparam int IRQ_OVERFLOW_BIT = 0;
    localparam int IRQ_AF_BIT = 1;
    localparam int IRQ_AE_BIT = 2;
    localparam int IRQ_WAKE_BIT = 3;

    // ========================================================
    // Reset values
    localparam logic CTRL_RST = 1'b0;
    localparam logic [CNT_W-1:0] FULL_OFS_RST = 7'h08;
    localparam logic [CNT_W-1:0] EMPTY_OFS_RST = 7'h08;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;
endpackage : queue_pkg

// [testbench/queue_echo_flags_tb.sv]
// Purpose: Self-checking bench for queue_echo_flags
// Assumes: One clock; writer model on the write port
// Notes: Runs both flag modes, fall-through and power-down
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
    mismatches++; $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end end
module queue_echo_flags_tb;
    import queue_pkg::*;
    logic core_clk, rstn, read_select_n, read_enable_n, output_enable_n;
    logic flag_timing_select, power_down_n, reg_write, reg_read;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic wsn, wen, data_out_oe, echo_read_enable_n, queue_empty_n;
    logic output_ready_n, almost_full_n, almost_empty_n, irq, af_s, ae_s;
    logic [DATA_W-1:0] wd, data_out_bus;
    int mismatches = 0;
    int tests_run = 0;
    int n;
    stream_writer stream_writer_i (.core_clk(core_clk),
        .write_select_n(wsn), .write_enable_n(wen), .write_data(wd));
    queue_echo_flags queue_echo_flags_i (.core_clk(core_clk), .rstn(rstn),
        .write_select_n(wsn), .write_enable_n(wen), .write_data(wd),
        .read_select_n(read_select_n), .read_enable_n(read_enable_n),
        .output_enable_n(output_enable_n), .data_out_bus(data_out_bus),
        .data_out_oe(data_out_oe), .echo_read_enable_n(echo_read_enable_n),
        .queue_empty_n(queue_empty_n), .output_ready_n(output_ready_n),
        .almost_full_n(almost_full_n), .almost_empty_n(almost_empty_n),
        .flag_timing_select(flag_timing_select),
        .power_down_n(power_down_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .irq(irq));
    // ========================================================
    // Clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        mismatches++;
        wrap_up();
    end
    // ========================================================
    // Access tasks
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask : reg_rd
    task automatic port(input logic rs, input logic re);
        @(posedge core_clk);
        read_select_n <= rs;
        read_enable_n <= re;
    endtask : port
    task automatic do_reset(input logic fts);
        @(posedge core_clk);
        rstn <= 1'b0;
        flag_timing_select <= fts;
        read_select_n <= 1'b1;
        read_enable_n <= 1'b1;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        @(negedge core_clk);
        `CHK("echo rst", 1'b1, echo_read_enable_n)
        `CHK("empty rst", 1'b0, queue_empty_n)
        `CHK("ae rst", 1'b0, almost_empty_n)
        `CHK("af rst", 1'b1, almost_full_n)
        reg_rd(CTRL_OFS, v);
        `CHK("ctrl rst", 1'b0, v[CTRL_FALL_THROUGH_MODE_BIT])
        reg_rd(FULL_OFS, v);
        `CHK("full rst", FULL_OFS_RST, v[CNT_W-1:0])
        reg_rd(EMPTY_OFS, v);
        `CHK("empty ofs rst", EMPTY_OFS_RST, v[CNT_W-1:0])
        reg_rd(IRQ_EN_OFS, v);
        `CHK("irq en rst", IRQ_EN_RST, v[IRQ_W-1:0])
        reg_rd(STATUS_OFS, v);
        `CHK("flag mode", fts, v[8])
    endtask : do_reset
    // ========================================================
    // Flags, interrupt and standard reads
    task automatic flag_test(input logic sync);
        do_reset(sync);
        reg_wr(FULL_OFS, 32'h3e);
        reg_wr(EMPTY_OFS, 32'h0);
        reg_wr(IRQ_EN_OFS, 32'h2);
        stream_writer_i.push(10'h155);
        @(negedge core_clk);
        `CHK("ae early", ~sync, almost_empty_n)
        @(negedge core_clk);
        `CHK("ae late", 1'b1, almost_empty_n)
        stream_writer_i.push(10'h2aa);
        @(negedge core_clk);
        `CHK("af early", sync, almost_full_n)
        @(negedge core_clk);
        `CHK("af late", 1'b0, almost_full_n)
        `CHK("irq on", 1'b1, irq)
        reg_rd(IRQ_STAT_OFS, v);
        `CHK("af event", 1'b1, v[IRQ_AF_BIT])
        reg_wr(IRQ_CLR_OFS, 32'h2);
        @(negedge core_clk);
        `CHK("irq off", 1'b0, irq)
        reg_rd(8'h20, v);
        `CHK("unmapped", 32'h0, v)
        reg_rd(STATUS_OFS, v);
        `CHK("count", 7'h02, v[6:0])
        port(1'b1, 1'b0);
        port(1'b0, 1'b0);
        @(negedge core_clk);
        `CHK("echo unsel", 1'b1, echo_read_enable_n)
        port(1'b1, 1'b1);
        @(negedge core_clk);
        `CHK("echo read", 1'b0, echo_read_enable_n)
        `CHK("af rel early", ~sync, almost_full_n)
        @(negedge core_clk);
        `CHK("echo back", 1'b1, echo_read_enable_n)
        `CHK("af rel late", 1'b1, almost_full_n)
        port(1'b0, 1'b0);
        port(1'b0, 1'b0);
        port(1'b1, 1'b1);
        @(negedge core_clk);
        `CHK("echo empty", 1'b1, echo_read_enable_n)
        `CHK("empty", 1'b0, queue_empty_n)
        $display("flag test done, sync %b", sync);
    endtask : flag_test
    // ========================================================
    // Fall-through reads and power-down
    task automatic fall_through_mode_test();
        do_reset(1'b1);
        reg_wr(CTRL_OFS, 32'h1);
        stream_writer_i.push(10'h0f0);
        n = 0;
        while (echo_read_enable_n !== 1'b0 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        `CHK("fall echo", 1'b0, echo_read_enable_n)
        `CHK("fall ready", 1'b0, output_ready_n)
        `CHK("fall oe", 1'b0, data_out_oe)
        @(negedge core_clk);
        `CHK("echo once", 1'b1, echo_read_enable_n)
        stream_writer_i.push(10'h30f);
        port(1'b0, 1'b1);
        @(negedge core_clk);
        `CHK("oe on", 1'b1, data_out_oe)
        `CHK("word a", 10'h0f0, data_out_bus)
        port(1'b0, 1'b0);
        port(1'b0, 1'b1);
        @(negedge core_clk);
        `CHK("echo next", 1'b0, echo_read_enable_n)
        `CHK("word b", 10'h30f, data_out_bus)
        port(1'b0, 1'b0);
        port(1'b0, 1'b1);
        @(negedge core_clk);
        `CHK("ready off", 1'b1, output_ready_n)
        `CHK("echo past", 1'b1, echo_read_enable_n)
        `CHK("empty past", 1'b0, queue_empty_n)
        $display("fall-through test done");
    endtask : fall_through_mode_test
    task automatic pd_test();
        repeat (QUIET_CYCLES) @(posedge core_clk);
        af_s = almost_full_n;
        ae_s = almost_empty_n;
        power_down_n <= 1'b0;
        repeat (8) @(negedge core_clk);
        `CHK("pd oe", 1'b0, data_out_oe)
        `CHK("pd af", af_s, almost_full_n)
        `CHK("pd ae", ae_s, almost_empty_n)
        reg_wr(FULL_OFS, 32'h10);
        @(posedge core_clk);
        power_down_n <= 1'b1;
        repeat (6) @(negedge core_clk);
        `CHK("wake oe", 1'b0, data_out_oe)
        repeat (16) @(negedge core_clk);
        `CHK("live oe", 1'b1, data_out_oe)
        reg_rd(FULL_OFS, v);
        `CHK("cfg kept", FULL_OFS_RST, v[CNT_W-1:0])
        reg_rd(IRQ_STAT_OFS, v);
        `CHK("wake event", 1'b1, v[IRQ_WAKE_BIT])
        $display("power-down test done");
    endtask : pd_test
    // ========================================================
    // Verdict
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        rstn = 1'b0;
        read_select_n = 1'b1;
        read_enable_n = 1'b1;
        output_enable_n = 1'b0;
        flag_timing_select = 1'b1;
        power_down_n = 1'b1;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        flag_test(1'b1);
        flag_test(1'b0);
        fall_through_mode_test();
        pd_test();
        wrap_up();
    end
endmodule : queue_echo_flags_tb
`default_nettype wire

// [testbench/stream_writer.sv]
// Purpose: Writer-side model driving the queue write port
// Assumes: Same clock as the queue; strobes active low
// Notes: Idle data shows the inverse of the last word
`timescale 1ns/100ps
`default_nettype none
module stream_writer (
    // Clock
    input wire logic core_clk,
    // Write port
    output var logic write_select_n,
    output var logic write_enable_n,
    output var logic [queue_pkg::DATA_W-1:0] write_data
);
    import queue_pkg::*;
    initial begin
        write_select_n = 1'b1;
        write_enable_n = 1'b1;
        write_data = '0;
    end
    // ========================================================
    // One word per taken edge
    task automatic push(input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        write_select_n <= 1'b0;
        write_enable_n <= 1'b0;
        write_data <= d;
        @(posedge core_clk);
        write_select_n <= 1'b1;
        write_enable_n <= 1'b1;
        write_data <= ~d;
    endtask : push
endmodule : stream_writer
`default_nettype wire
